// *** core/dual_timer_consts.vh ***
// Constants for the cascadable dual 16-bit timer
`ifndef DUAL_TIMER_CONSTS_VH
`define DUAL_TIMER_CONSTS_VH
// Control word field positions
`define CTL_TIMER_ON_BIT      15
`define CTL_IDLE_STOP_BIT     13
`define CTL_GATE_ACC_BIT      6
`define CTL_PRESCALE_HI_BIT   5
`define CTL_PRESCALE_LO_BIT   4
`define CTL_WIDE_MODE_BIT     3
`define CTL_CLK_SRC_BIT       1
// Reset values
`define CTL_RESET_VALUE       16'h0000
`define PERIOD_RESET_VALUE    16'hFFFF
`define COUNT_RESET_VALUE     16'h0000
// Prescaler terminal counts (ratio minus one)
`define PRESCALE_WIDTH        8
`define PRESCALE_TC_1         8'h00
`define PRESCALE_TC_8         8'h07
`define PRESCALE_TC_64        8'h3F
`define PRESCALE_TC_256       8'hFF
`endif

// *** core/dual_timer.v ***
// Cascadable dual 16-bit timer / 32-bit timer and synchronous counter
//
// Contract
// - Two 16-bit units, or one 32-bit timer/counter
// - Each half: instruction-cycle timer or synchronous counter
// - Only low half synchronizes its prescaler output
// - Low counter bits 15..0, high counter 31..16
// - Wide mode uses only low-half control settings
// - Wide mode: low pins in, high flag out
// - Wide timer counts cycles, wraps at period
// - Wide low-word read latches high word into holding
// - Wide low-word write copies holding into high counter
// - Wide counter counts synchronized external rising edges
// - Idle-stop bit halts counting during CPU idle
// - Gate mode counts cycles while gate high
// - Wide gate source is low half; high ignores gate
// - Gate fall stops, keeps count; software clears
// - Wide period match pulses converter trigger
// - Prescaler ratio 1, 8, 64 or 256
// - Prescaler clears on count write, on-clear, reset
// - Match or gate fall sets its half's flag; wide mode sets high flag
// - No counting during CPU sleep
`timescale 1ns/1ps
`include "dual_timer_consts.vh"

module dual_timer (
  // Clock and reset
  input  wire        core_clk,
  input  wire        sys_rst,
  // CPU power state
  input  wire        cpu_idle,
  input  wire        cpu_sleep,
  // External clock / gate pins
  input  wire        low_half_ext_clock_pin,
  input  wire        high_half_ext_clock_pin,
  // Control words
  input  wire [15:0] low_half_control,
  input  wire [15:0] high_half_control,
  // Period words
  input  wire [15:0] period_low_word,
  input  wire [15:0] period_high_word,
  // Counter and holding access
  input  wire        low_count_wr,
  input  wire        high_count_wr,
  input  wire        holding_wr,
  input  wire        low_count_rd,
  input  wire [15:0] wr_data,
  // Interrupt flag control
  input  wire        low_flag_clr,
  input  wire        high_flag_clr,
  input  wire        low_half_match_irq_enable,
  input  wire        high_half_match_irq_enable,
  // Status outputs
  output reg  [15:0] low_word_count,
  output reg  [15:0] high_word_count,
  output reg  [15:0] high_word_holding,
  output reg         low_half_match_flag,
  output reg         high_half_match_flag,
  output wire        low_half_irq,
  output wire        high_half_irq,
  output reg         adc_trigger
);

  // ==========================================================
  // Pin synchronisers
  reg [1:0] lo_pin_sync_reg;
  reg [1:0] hi_pin_sync_reg;
  reg       lo_pin_prev_reg;
  reg       hi_pin_prev_reg;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lo_pin_sync_reg <= 2'h0;
      hi_pin_sync_reg <= 2'h0;
      lo_pin_prev_reg <= 1'b0;
      hi_pin_prev_reg <= 1'b0;
    end else begin
      lo_pin_sync_reg <= {lo_pin_sync_reg[0], low_half_ext_clock_pin};
      hi_pin_sync_reg <= {hi_pin_sync_reg[0], high_half_ext_clock_pin};
      lo_pin_prev_reg <= lo_pin_sync_reg[1];
      hi_pin_prev_reg <= hi_pin_sync_reg[1];
    end
  end

  wire lo_pin  = lo_pin_sync_reg[1];
  wire lo_rise = lo_pin & ~lo_pin_prev_reg;
  wire lo_fall = ~lo_pin & lo_pin_prev_reg;
  wire hi_rise = hi_pin_sync_reg[1] & ~hi_pin_prev_reg;

  // ==========================================================
  // Control decode
  wire wide_mode_select = low_half_control[`CTL_WIDE_MODE_BIT];
  // High half takes its own control only when not cascaded
  wire [15:0] hi_ctl = wide_mode_select ? low_half_control : high_half_control;

  wire lo_on    = low_half_control[`CTL_TIMER_ON_BIT];
  wire hi_on    = high_half_control[`CTL_TIMER_ON_BIT];
  wire lo_gate  = low_half_control[`CTL_GATE_ACC_BIT] & ~low_half_control[`CTL_CLK_SRC_BIT];
  wire hi_gate  = ~wide_mode_select & high_half_control[`CTL_GATE_ACC_BIT]
                  & ~high_half_control[`CTL_CLK_SRC_BIT];

  // Idle and sleep stall; idle stalls only with idle-stop set
  wire lo_run = ~cpu_sleep & ~(cpu_idle & low_half_control[`CTL_IDLE_STOP_BIT]);
  wire hi_run = ~cpu_sleep & ~(cpu_idle & high_half_control[`CTL_IDLE_STOP_BIT]);

  // Prescaler input tick: cycle, gated cycle or external edge
  wire lo_in = low_half_control[`CTL_CLK_SRC_BIT] ? lo_rise :
               (lo_gate ? lo_pin : 1'b1);
  wire hi_in = high_half_control[`CTL_CLK_SRC_BIT] ? hi_rise :
               (hi_gate ? hi_pin_sync_reg[1] : 1'b1);

  // Prescale terminal count
  function [`PRESCALE_WIDTH-1:0] ps_tc;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    ps_tc = `PRESCALE_TC_1;
        2'h1:    ps_tc = `PRESCALE_TC_8;
        2'h2:    ps_tc = `PRESCALE_TC_64;
        default: ps_tc = `PRESCALE_TC_256;
      endcase
    end
  endfunction

  // ==========================================================
  // Prescalers
  reg [`PRESCALE_WIDTH-1:0] lo_ps_reg;
  reg [`PRESCALE_WIDTH-1:0] hi_ps_reg;
  reg                       lo_on_prev_reg;
  reg                       hi_on_prev_reg;
  reg                       lo_tick_reg;

  wire lo_ps_clr = low_count_wr | high_count_wr | (lo_on_prev_reg & ~lo_on);
  wire hi_ps_clr = low_count_wr | high_count_wr | (hi_on_prev_reg & ~hi_on);
  wire lo_ps_adv = lo_on & lo_run & lo_in;
  wire hi_ps_adv = hi_on & hi_run & hi_in & ~wide_mode_select;
  wire lo_ps_out = lo_ps_adv &
    (lo_ps_reg == ps_tc(low_half_control[`CTL_PRESCALE_HI_BIT:`CTL_PRESCALE_LO_BIT]));
  wire hi_tick   = hi_ps_adv &
    (hi_ps_reg == ps_tc(hi_ctl[`CTL_PRESCALE_HI_BIT:`CTL_PRESCALE_LO_BIT]));

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lo_ps_reg      <= {`PRESCALE_WIDTH{1'b0}};
      hi_ps_reg      <= {`PRESCALE_WIDTH{1'b0}};
      lo_on_prev_reg <= 1'b0;
      hi_on_prev_reg <= 1'b0;
      lo_tick_reg    <= 1'b0;
    end else begin
      lo_on_prev_reg <= lo_on;
      hi_on_prev_reg <= hi_on;
      // Low half re-times its prescaler output to the core clock
      lo_tick_reg    <= lo_ps_out & ~lo_ps_clr;
      if (lo_ps_clr)
        lo_ps_reg <= {`PRESCALE_WIDTH{1'b0}};
      else if (lo_ps_out)
        lo_ps_reg <= {`PRESCALE_WIDTH{1'b0}};
      else if (lo_ps_adv)
        lo_ps_reg <= lo_ps_reg + 8'h01;
      if (hi_ps_clr)
        hi_ps_reg <= {`PRESCALE_WIDTH{1'b0}};
      else if (hi_tick)
        hi_ps_reg <= {`PRESCALE_WIDTH{1'b0}};
      else if (hi_ps_adv)
        hi_ps_reg <= hi_ps_reg + 8'h01;
    end
  end

  // ==========================================================
  // Counters, match and flags
  wire lo_match   = (low_word_count == period_low_word);
  wire hi_match   = (high_word_count == period_high_word);
  wire wide_match = lo_match & hi_match;
  wire lo_step    = lo_tick_reg & lo_on;
  wire hi_step    = hi_tick & ~high_count_wr;
  // Gate fall ends accumulation; count is kept
  wire gate_end   = lo_on & lo_gate & lo_fall & ~cpu_sleep;
  wire hi_gate_end = ~wide_mode_select & hi_on & hi_gate & ~hi_pin_sync_reg[1] & hi_pin_prev_reg;
  wire wide_evt   = wide_mode_select & lo_step & wide_match;
  wire lo_evt     = ~wide_mode_select & ((lo_step & lo_match) | gate_end);
  wire hi_evt     = wide_evt | (wide_mode_select & gate_end) |
                    (~wide_mode_select & ((hi_step & hi_match) | hi_gate_end));

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_word_count       <= `COUNT_RESET_VALUE;
      high_word_count      <= `COUNT_RESET_VALUE;
      high_word_holding    <= `COUNT_RESET_VALUE;
      low_half_match_flag  <= 1'b0;
      high_half_match_flag <= 1'b0;
      adc_trigger          <= 1'b0;
    end else begin
      // Holding register: read snapshot or software load
      if (low_count_rd & wide_mode_select)
        high_word_holding <= high_word_count;
      else if (holding_wr)
        high_word_holding <= wr_data;
      // Low word
      if (low_count_wr)
        low_word_count <= wr_data;
      else if (lo_step)
        low_word_count <= (wide_mode_select ? wide_match : lo_match) ?
                          16'h0000 : low_word_count + 16'h0001;
      // High word
      if (wide_mode_select) begin
        if (low_count_wr)
          high_word_count <= high_word_holding;
        else if (high_count_wr)
          high_word_count <= wr_data;
        else if (lo_step & wide_match)
          high_word_count <= 16'h0000;
        else if (lo_step & (low_word_count == 16'hFFFF))
          high_word_count <= high_word_count + 16'h0001;
      end else if (high_count_wr)
        high_word_count <= wr_data;
      else if (hi_step)
        high_word_count <= hi_match ? 16'h0000 : high_word_count + 16'h0001;
      // Flags: a new event wins over a clear
      if (lo_evt)
        low_half_match_flag <= 1'b1;
      else if (low_flag_clr)
        low_half_match_flag <= 1'b0;
      if (hi_evt)
        high_half_match_flag <= 1'b1;
      else if (high_flag_clr)
        high_half_match_flag <= 1'b0;
      adc_trigger <= wide_evt;
    end
  end

  // Interrupt requests gated by the enables
  assign low_half_irq  = low_half_match_flag & low_half_match_irq_enable;
  assign high_half_irq = high_half_match_flag & high_half_match_irq_enable;

endmodule

// *** tb/timer_monitor.sv ***
// Port checker for the cascadable dual timer
`timescale 1ns/1ps
module timer_monitor (
  // Clock and reset
  input wire        core_clk,
  input wire        sys_rst,
  // Watched inputs
  input wire        cpu_idle,
  input wire        cpu_sleep,
  input wire [15:0] low_half_control,
  input wire        low_count_wr,
  input wire        holding_wr,
  input wire        low_count_rd,
  input wire        high_flag_clr,
  input wire        high_half_match_irq_enable,
  // Watched outputs
  input wire [15:0] low_word_count,
  input wire [15:0] high_word_count,
  input wire [15:0] high_word_holding,
  input wire        high_half_match_flag,
  input wire        high_half_irq,
  input wire        adc_trigger
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================
  // Quiet spans: three edges asleep or idle-stopped, no count write
  sequence s_asleep; (cpu_sleep && !low_count_wr) [*3]; endsequence
  sequence s_idled; (cpu_idle && low_half_control[13] && !low_count_wr) [*3]; endsequence
  property p_trig_pulse; adc_trigger |=> !adc_trigger; endproperty
  property p_trig_wrap; adc_trigger |-> high_half_match_flag && {high_word_count, low_word_count} == 32'h0; endproperty
  property p_flag_hold; high_half_match_flag && !high_flag_clr |=> high_half_match_flag; endproperty
  property p_irq; high_half_irq == (high_half_match_flag && high_half_match_irq_enable); endproperty
  property p_copy; low_count_wr && low_half_control[3] |=> high_word_count == $past(high_word_holding); endproperty
  property p_snap; low_count_rd && low_half_control[3] && !holding_wr |=> high_word_holding == $past(high_word_count);
  endproperty
  property p_sleep; s_asleep |=> $stable(low_word_count); endproperty
  property p_idle; s_idled |=> $stable(low_word_count); endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger longer than one cycle");
  a_trig_wrap: assert property (p_trig_wrap) else $error("trigger without wrap or flag");
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");
  a_irq: assert property (p_irq) else $error("irq not flag and enable");
  a_copy: assert property (p_copy) else $error("holding not copied to high word");
  a_snap: assert property (p_snap) else $error("high word not snapped on read");
  a_sleep: assert property (p_sleep) else $error("count moved in sleep");
  a_idle: assert property (p_idle) else $error("count moved in stopped idle");
endmodule
bind dual_timer timer_monitor mon_u (.*);

// *** tb/ext_pin_source.sv ***
// Model of the external clock or gate source
`timescale 1ns/1ps
module ext_pin_source (
  // Clock
  input  wire       core_clk,
  // Bench control
  input  wire       run,
  input  wire [7:0] half_cycles,
  // Pin level
  output reg        pin = 1'b0
);
  reg [7:0] span_reg = 8'h00;
  // Square wave while running; parked low between bursts like a pull-down
  always @(posedge core_clk) begin
    if (!run) begin
      pin <= 1'b0;
      span_reg <= 8'h00;
    end else if (span_reg == half_cycles - 8'h01) begin
      pin <= ~pin;
      span_reg <= 8'h00;
    end else begin
      span_reg <= span_reg + 8'h01;
    end
  end
endmodule

// *** tb/dual_timer_tb_top.sv ***
// Self-checking bench of the cascadable dual timer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked = checked + 1; if ((got) !== (ex)) begin bad_count = bad_count + 1; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module dual_timer_tb_top;
  localparam [15:0] ON = 16'h8000, IDL = 16'h2000, GATE = 16'h0040, PS8 = 16'h0010, WIDE = 16'h0008, EXT = 16'h0002;
  reg         core_clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         cpu_idle = 1'b0;
  reg         cpu_sleep = 1'b0;
  reg  [15:0] lctl = 16'h0000;
  reg  [15:0] hctl = 16'h0000;
  reg  [15:0] plo = 16'hFFFF;
  reg  [15:0] phi = 16'hFFFF;
  reg  [15:0] wd = 16'h0000;
  reg  [15:0] c = 16'h0000;
  reg  [5:0]  pls = 6'h00;
  reg  [7:0]  half = 8'h02;
  reg         run = 1'b0;
  reg         hie = 1'b1;
  wire        pin;
  wire [15:0] lo, hi, hold;
  wire        lflag, lirq, hflag, hirq, trig;
  integer     bad_count = 0, checked = 0, trig_cnt = 0, i;
  // Design and far-side source
  dual_timer dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
    .low_half_ext_clock_pin(pin), .high_half_ext_clock_pin(pin), .low_half_control(lctl),
    .high_half_control(hctl), .period_low_word(plo), .period_high_word(phi), .low_count_wr(pls[0]),
    .high_count_wr(pls[1]), .holding_wr(pls[2]), .low_count_rd(pls[3]), .wr_data(wd), .low_flag_clr(pls[4]),
    .high_flag_clr(pls[5]), .low_half_match_irq_enable(1'b1), .high_half_match_irq_enable(hie),
    .low_word_count(lo), .high_word_count(hi), .high_word_holding(hold), .low_half_match_flag(lflag),
    .high_half_match_flag(hflag), .low_half_irq(lirq), .high_half_irq(hirq), .adc_trigger(trig));
  ext_pin_source src_u (.core_clk(core_clk), .run(run), .half_cycles(half), .pin(pin));
  // Clock and trigger tally
  initial forever #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (trig === 1'b1) trig_cnt <= trig_cnt + 1;
  // One-cycle strobes with data
  task strobe(input [5:0] p, input [15:0] d);
    begin
      @(negedge core_clk); pls = p; wd = d;
      @(negedge core_clk); pls = 6'h00;
    end
  endtask
  task wait_n(input integer n);
    repeat (n) @(negedge core_clk);
  endtask
  task end_of_test;
    begin
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    #120000;
    bad_count = bad_count + 1;
    end_of_test;
  end
  // ==========================================
  // Main sequence
  initial begin
    wait_n(8); sys_rst = 1'b0;
    plo = 16'h0003; hctl = ON; lctl = ON; wait_n(40);
    `CHK("low wrap flag", 1'b1, lflag)
    `CHK("low in period", 1'b1, lo <= 16'h0003)
    `CHK("no wide trigger", 0, trig_cnt)
    hctl = 16'h8030; plo = 16'h0002; phi = 16'h0001; lctl = WIDE;
    strobe(6'h12, 16'h0000); strobe(6'h04, 16'h0001); strobe(6'h01, 16'h0000);
    `CHK("paired high", 16'h0001, hi)
    lctl = ON | WIDE;
    for (i = 0; i < 30 && trig_cnt == 0; i = i + 1) wait_n(1);
    wait_n(1);
    `CHK("one trigger", 1, trig_cnt)
    `CHK("high irq", 1'b1, hirq)
    `CHK("low flag quiet", 1'b0, lflag)
    `CHK("high wrapped", 16'h0000, hi)
    hie = 1'b0; wait_n(1);
    `CHK("high irq masked", 1'b0, hirq)
    lctl = WIDE;
    strobe(6'h04, 16'hABCD); strobe(6'h01, 16'h1234);
    `CHK("high word", 16'hABCD, hi)
    `CHK("low word", 16'h1234, lo)
    strobe(6'h04, 16'h5555); strobe(6'h08, 16'h0000);
    `CHK("snapshot", 16'hABCD, hold)
    strobe(6'h20, 16'h0000);
    `CHK("flag cleared", 1'b0, hflag)
    plo = 16'hFFFF; lctl = ON | IDL; cpu_idle = 1'b1; wait_n(3); c = lo; wait_n(10);
    `CHK("idle hold", c, lo)
    cpu_idle = 1'b0; wait_n(5);
    `CHK("idle resume", 1'b1, lo != c)
    cpu_sleep = 1'b1; wait_n(3); c = lo; wait_n(10);
    `CHK("sleep hold", c, lo)
    cpu_sleep = 1'b0; lctl = 16'h0000; strobe(6'h11, 16'h0000);
    lctl = ON | GATE; half = 8'h0A; run = 1'b1; wait_n(25); run = 1'b0; wait_n(10);
    `CHK("gated count", 16'h000A, lo)
    `CHK("gate fall flag", 1'b1, lflag)
    `CHK("gate fall irq", 1'b1, lirq)
    wait_n(10);
    `CHK("gated kept", 16'h000A, lo)
    lctl = 16'h0000; hctl = 16'h0000; phi = 16'hFFFF; strobe(6'h03, 16'h0000);
    lctl = ON | EXT | PS8; hctl = ON | EXT | PS8; half = 8'h02; run = 1'b1; wait_n(64); run = 1'b0; wait_n(10);
    `CHK("ext count by 8", 16'h0002, lo)
    `CHK("high ext count by 8", 16'h0002, hi)
    end_of_test;
  end
endmodule
